// [tqp_map.svh]
`ifndef TQP_MAP_SVH
`define TQP_MAP_SVH
// Register byte offsets
`define TQP_CTL_OFF 8'h00
`define TQP_IOC_OFF 8'h04
`define TQP_IER_OFF 8'h08
`define TQP_STS_OFF 8'h0C
`define TQP_CNT_OFF 8'h10
`define TQP_GRA_OFF 8'h14
`define TQP_GRB_OFF 8'h18
// Control fields
`define TQP_CLR_F 1:0
`define TQP_PSC_F 3:2
`define TQP_EDG_F 5:4
`define TQP_MOD_F 8:6
`define TQP_CID_F 11:9
// I/O control fields
`define TQP_LVA_F 1:0
`define TQP_INA_B 2
`define TQP_CPA_B 3
`define TQP_LVB_F 5:4
`define TQP_INB_B 6
`define TQP_CPB_B 7
// Status bit positions
`define TQP_FA_B 0
`define TQP_FB_B 1
`define TQP_OVF_B 4
`define TQP_UNF_B 5
`define TQP_DIR_B 7
// Mode codes
`define TQP_M_NORM 3'h0
`define TQP_M_PWM1 3'h2
`define TQP_M_PWM2 3'h3
// Clear sources
`define TQP_CLR_A 2'h1
`define TQP_CLR_B 2'h2
// Prescaler end counts
`define TQP_DIV0 6'h00
`define TQP_DIV1 6'h03
`define TQP_DIV2 6'h0F
`define TQP_DIV3 6'h3F
// Reset values that are not zero
`define TQP_DIR_RST 1'b1
`define TQP_GR_RST 16'hFFFF
`endif

// [tqp_pkg.sv]
package tqp_pkg;
    typedef struct packed {
        logic [3:0] s1;
        logic [3:0] s2;
        logic [3:0] s3;
        logic [5:0] div;
        logic [11:0] ctl;
        logic [7:0] ioc;
        logic [2:0] ier;
        logic fa;
        logic fb;
        logic ovf;
        logic unf;
        logic dir;
        logic [15:0] cnt;
        logic [15:0] gra;
        logic [15:0] grb;
        logic out_a;
        logic out_b;
        logic cp;
        logic [31:0] rdata;
    } tqp_state_t;
endpackage

// [tqp_channel.sv]
// Contract
// - Phase counting only on channels 1,2,4,5
// - Phase mode ignores prescaler and edge select
// - Clear, io control, enables, compares stay active
// - Overflow flag up, underflow flag down
// - Readable count direction flag
// - Channels 1,5 pins A,B; 2,4 C,D
// - Four selectable phase counting sub-modes
// - Sub-mode 1 counts every edge
// - Sub-mode 2 counts A falling only
// - Sub-mode 3: A fall up, B fall down
// - Sub-mode 4 counts B edges only
// - PWM1: A sets period, B duty
// - PWM2: clear register period, other duty
// - PWM gives 0%, 100% and between
// - Count clock offered as channel 0 capture
// - Channel 0 matches A,C trigger captures
// - PWM1 pin takes A level then B level
// - Equal period and duty leave output unchanged
//
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "tqp_map.svh"
`default_nettype none
module tqp_channel
    import tqp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_phase_pin_a,
    input wire logic ext_phase_pin_b,
    input wire logic ext_phase_pin_c,
    input wire logic ext_phase_pin_d,
    input wire logic chan0_match_a,
    input wire logic chan0_match_c,
    output logic out_a,
    output logic out_b,
    output logic count_pulse
);
    tqp_state_t r;
    tqp_state_t n;
    logic wr, rd, hit;
    logic phase_ok, phase, cd;
    logic a, b, pa, pb, ra, fa, rb, fb;
    logic up, dn, up_step, dn_step, step, tick;
    logic match_a, match_b, cap_a, cap_b, clear;
    logic [5:0] div_end;
    logic [2:0] mode;
    logic [1:0] clr_sel;

    // Output level per io code: low, high, toggle, hold
    function automatic logic lvl(input logic [1:0] code, input logic cur);
        unique case (code)
            2'h0: lvl = 1'b0;
            2'h1: lvl = 1'b1;
            2'h2: lvl = ~cur;
            default: lvl = cur;
        endcase
    endfunction

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    // Zero wait state: read data is staged in the setup cycle
    assign wr = psel & penable & pwrite;
    assign rd = psel & ~penable & ~pwrite;
    assign hit = (paddr <= `TQP_GRB_OFF) && (paddr[1:0] == 2'h0);
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit;
    assign prdata = r.rdata;
    assign out_a = r.out_a;
    assign out_b = r.out_b;
    assign count_pulse = r.cp;

    // ----------------------------------------
    // Counting
    // ----------------------------------------
    assign mode = r.ctl[`TQP_MOD_F];
    assign clr_sel = r.ctl[`TQP_CLR_F];
    assign phase_ok = (r.ctl[`TQP_CID_F] == 3'h1) || (r.ctl[`TQP_CID_F] == 3'h2)
        || (r.ctl[`TQP_CID_F] == 3'h4) || (r.ctl[`TQP_CID_F] == 3'h5);
    assign phase = mode[2] & phase_ok;
    assign cd = (r.ctl[`TQP_CID_F] == 3'h2) || (r.ctl[`TQP_CID_F] == 3'h4);
    // Edges come from the synchronised stages only, never from s1
    assign a = cd ? r.s2[2] : r.s2[0];
    assign b = cd ? r.s2[3] : r.s2[1];
    assign pa = cd ? r.s3[2] : r.s3[0];
    assign pb = cd ? r.s3[3] : r.s3[1];
    assign ra = a & ~pa;
    assign fa = ~a & pa;
    assign rb = b & ~pb;
    assign fb = ~b & pb;

    // Count conditions per sub-mode
    always_comb begin
        unique case (mode[1:0])
            2'h0: begin
                up = (rb & a) | (fb & ~a) | (ra & ~b) | (fa & b);
                dn = (rb & ~a) | (fb & a) | (ra & b) | (fa & ~b);
            end
            2'h1: begin
                up = fa & b;
                dn = fa & ~b;
            end
            2'h2: begin
                up = fa & b;
                dn = fb & a;
            end
            default: begin
                up = (rb & a) | (fb & ~a);
                dn = (fb & a) | (rb & ~a);
            end
        endcase
    end

    // Prescaler only serves the internal clock
    always_comb begin
        unique case (r.ctl[`TQP_PSC_F])
            2'h0: div_end = `TQP_DIV0;
            2'h1: div_end = `TQP_DIV1;
            2'h2: div_end = `TQP_DIV2;
            default: div_end = `TQP_DIV3;
        endcase
    end
    assign tick = (r.div == div_end);

    // Phase mode bypasses prescaler and edge select entirely
    assign up_step = phase ? (up & ~dn) : tick;
    assign dn_step = phase & dn & ~up;
    assign step = up_step | dn_step;
    assign cap_a = r.ioc[`TQP_CPA_B] & chan0_match_a;
    assign cap_b = r.ioc[`TQP_CPB_B] & chan0_match_c;
    assign match_a = step & ~r.ioc[`TQP_CPA_B] & (r.cnt == r.gra);
    assign match_b = step & ~r.ioc[`TQP_CPB_B] & (r.cnt == r.grb);
    assign clear = ((clr_sel == `TQP_CLR_A) & (match_a | cap_a))
        | ((clr_sel == `TQP_CLR_B) & (match_b | cap_b));

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        n = r;
        n.s1 = {ext_phase_pin_d, ext_phase_pin_c, ext_phase_pin_b, ext_phase_pin_a};
        n.s2 = r.s1;
        n.s3 = r.s2;
        n.div = tick ? 6'h00 : r.div + 6'h01;
        n.cp = step;
        // Counter wraps naturally at 16 bits
        if (clear) begin
            n.cnt = 16'h0000;
        end else if (up_step) begin
            n.cnt = r.cnt + 16'h0001;
        end else if (dn_step) begin
            n.cnt = r.cnt - 16'h0001;
        end
        if (up_step) begin
            n.dir = 1'b1;
        end else if (dn_step) begin
            n.dir = 1'b0;
        end
        if (cap_a) begin
            n.gra = r.cnt;
        end
        if (cap_b) begin
            n.grb = r.cnt;
        end
        // Compare outputs; in the PWM modes equal registers suppress the change
        if (mode == `TQP_M_PWM1) begin
            if (match_a && r.gra != r.grb) begin
                n.out_a = lvl(r.ioc[`TQP_LVA_F], r.out_a);
            end else if (match_b && r.gra != r.grb) begin
                n.out_a = lvl(r.ioc[`TQP_LVB_F], r.out_a);
            end
        end else if (mode == `TQP_M_PWM2) begin
            if (clr_sel == `TQP_CLR_A) begin
                if (clear) begin
                    n.out_b = r.ioc[`TQP_INB_B];
                end else if (match_b && r.gra != r.grb) begin
                    n.out_b = lvl(r.ioc[`TQP_LVB_F], r.out_b);
                end
            end else if (clr_sel == `TQP_CLR_B) begin
                if (clear) begin
                    n.out_a = r.ioc[`TQP_INA_B];
                end else if (match_a && r.gra != r.grb) begin
                    n.out_a = lvl(r.ioc[`TQP_LVA_F], r.out_a);
                end
            end
        end else begin
            if (match_a) begin
                n.out_a = lvl(r.ioc[`TQP_LVA_F], r.out_a);
            end
            if (match_b) begin
                n.out_b = lvl(r.ioc[`TQP_LVB_F], r.out_b);
            end
        end
        // Register writes; hardware captures win over software
        if (wr) begin
            unique case (paddr)
                `TQP_CTL_OFF: n.ctl = pwdata[11:0];
                `TQP_IOC_OFF: begin
                    n.ioc = pwdata[7:0];
                    n.out_a = pwdata[`TQP_INA_B];
                    n.out_b = pwdata[`TQP_INB_B];
                end
                `TQP_IER_OFF: n.ier = pwdata[2:0];
                `TQP_CNT_OFF: n.cnt = pwdata[15:0];
                `TQP_GRA_OFF: n.gra = cap_a ? r.cnt : pwdata[15:0];
                `TQP_GRB_OFF: n.grb = cap_b ? r.cnt : pwdata[15:0];
                default: n.ctl = r.ctl;
            endcase
        end
        // Write one clears a flag; a new event in that cycle wins
        n.fa = (r.fa & ~(wr & paddr == `TQP_STS_OFF & pwdata[`TQP_FA_B]))
            | match_a | cap_a;
        n.fb = (r.fb & ~(wr & paddr == `TQP_STS_OFF & pwdata[`TQP_FB_B]))
            | match_b | cap_b;
        n.ovf = (r.ovf & ~(wr & paddr == `TQP_STS_OFF & pwdata[`TQP_OVF_B]))
            | (up_step & ~clear & r.cnt == 16'hFFFF);
        n.unf = (r.unf & ~(wr & paddr == `TQP_STS_OFF & pwdata[`TQP_UNF_B]))
            | (dn_step & ~clear & r.cnt == 16'h0000);
        // Read data staged for the access phase
        n.rdata = 32'h0000_0000;
        if (rd) begin
            unique case (paddr)
                `TQP_CTL_OFF: n.rdata[11:0] = r.ctl;
                `TQP_IOC_OFF: n.rdata[7:0] = r.ioc;
                `TQP_IER_OFF: n.rdata[2:0] = r.ier;
                `TQP_STS_OFF: begin
                    n.rdata[`TQP_FA_B] = r.fa;
                    n.rdata[`TQP_FB_B] = r.fb;
                    n.rdata[`TQP_OVF_B] = r.ovf;
                    n.rdata[`TQP_UNF_B] = r.unf;
                    n.rdata[`TQP_DIR_B] = r.dir;
                end
                `TQP_CNT_OFF: n.rdata[15:0] = r.cnt;
                `TQP_GRA_OFF: n.rdata[15:0] = r.gra;
                `TQP_GRB_OFF: n.rdata[15:0] = r.grb;
                default: n.rdata = 32'h0000_0000;
            endcase
        end
    end

    // State register; direction resets to up
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // Compare registers start at all ones so no match fires soon after reset
            r <= '0;
            r.dir <= `TQP_DIR_RST;
            r.gra <= `TQP_GR_RST;
            r.grb <= `TQP_GR_RST;
        end else begin
            r <= n;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    // All checks run in the one pclk domain and sleep during reset
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Flag setting on wrap; set wins over a software clear in the same cycle
    ovf_set_a: assert property (up_step && !clear && r.cnt == 16'hFFFF |=> r.ovf)
        else $error("overflow flag not set");
    unf_set_a: assert property (dn_step && !clear && r.cnt == 16'h0000 |=> r.unf)
        else $error("underflow flag not set");
    wrap_down_a: assert property (dn_step && !clear && !wr && r.cnt == 16'h0000
        |=> r.cnt == 16'hFFFF)
        else $error("counter did not wrap down");
    flag_wins_a: assert property (match_a || cap_a |=> r.fa)
        else $error("compare flag lost to a clear");

    // A down step must move the count by exactly one, not only flip the flag
    dir_down_a: assert property (dn_step && !clear && !wr
        |=> !r.dir && r.cnt == $past(r.cnt) - 16'h0001)
        else $error("direction flag not down");
    dir_up_a: assert property (up_step |=> r.dir)
        else $error("direction flag not up");
    pulse_out_a: assert property (step |=> count_pulse)
        else $error("count pulse missing");
    // An unsupported channel id falls back to the prescaled up count
    bad_chan_a: assert property (mode[2] && !phase_ok && !clear && !wr
        |=> r.cnt == $past(r.cnt) + ($past(tick) ? 16'h0001 : 16'h0000))
        else $error("phase count on illegal channel");
    // Without a phase edge the count holds, however the prescaler ticks
    psc_ignored_a: assert property (phase && !(ra || fa || rb || fb) && !clear && !wr
        |=> r.cnt == $past(r.cnt))
        else $error("phase count moved without an edge");
    clear_zero_a: assert property (clear && !wr |=> r.cnt == 16'h0000)
        else $error("counter not cleared");

    // Count tables, one check per sub-mode, two for sub-mode 3
    sub1_edge_a: assert property (phase && mode[1:0] == 2'h0 && (ra || fa) && !(rb || fb)
        |-> step)
        else $error("sub-mode 1 missed an edge");
    mode2_edge_a: assert property (phase && mode[1:0] == 2'h1 && !fa |-> !step)
        else $error("sub-mode 2 counted wrong edge");
    sub3_up_a: assert property (phase && mode[1:0] == 2'h2 && fa && b |-> up_step)
        else $error("sub-mode 3 missed an up count");
    sub3_down_a: assert property (phase && mode[1:0] == 2'h2 && fb && a |-> dn_step)
        else $error("sub-mode 3 missed a down count");
    sub4_edge_a: assert property (phase && mode[1:0] == 2'h3 && !rb && !fb |-> !step)
        else $error("sub-mode 4 counted an A edge");

    // Pin edge to count step takes exactly two synchroniser stages
    sync_lat_a: assert property (phase && mode[1:0] == 2'h0 && !cd && !r.s2[1]
        && $rose(ext_phase_pin_a) ##1 !r.s1[1] ##1 !r.s2[1] |-> up_step)
        else $error("sync latency wrong");
    cap_val_a: assert property (cap_a && !wr |=> r.gra == $past(r.cnt) && r.fa)
        else $error("capture value wrong");

    // Output pins in the PWM modes
    pwm_hold_a: assert property (mode == `TQP_M_PWM1 && match_a && r.gra == r.grb && !wr
        |=> $stable(r.out_a))
        else $error("output changed on equal registers");
    pwm1_duty_a: assert property (mode == `TQP_M_PWM1 && match_b && !match_a
        && r.gra != r.grb && r.ioc[`TQP_LVB_F] == 2'h1 && !wr |=> r.out_a)
        else $error("duty match did not drive its level");
    pwm2_init_a: assert property (mode == `TQP_M_PWM2 && clr_sel == `TQP_CLR_A
        && clear && !wr |=> r.out_b == $past(r.ioc[`TQP_INB_B]))
        else $error("period clear did not restore initial level");

    // ----------------------------------------
    // Cover points
    // ----------------------------------------
    // Main scenarios; the bench reaches all but cover_up_dn, as it never drives a down step right after an up step
    cover_up_dn: cover property (up_step ##1 dn_step);
    cover_ovf: cover property (phase && up_step && r.cnt == 16'hFFFF);
    cover_unf: cover property (phase && dn_step && r.cnt == 16'h0000);
    cover_pwm: cover property (mode == `TQP_M_PWM1 && match_b ##[1:300] match_a);
    cover_pwm2: cover property (mode == `TQP_M_PWM2 && clear);
endmodule // tqp_channel
`default_nettype wire

// [tqp_encoder.sv]
`timescale 1ns/1ps
`default_nettype none
module tqp_encoder (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic step,
    input wire logic up,
    output logic phase_a,
    output logic phase_b
);
    // ----------------------------------------
    // Encoder position
    // ----------------------------------------
    logic [1:0] pos;

    // One phase changes per step, so the two phases never move together
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pos <= 2'h0;
        end else if (step) begin
            pos <= up ? pos + 2'h1 : pos - 2'h1;
        end
    end

    // Forward order 00,10,11,01 (a,b): A leads B when moving up
    assign phase_a = pos[0] ^ pos[1];
    assign phase_b = pos[1];
endmodule // tqp_encoder
`default_nettype wire

// [timer_quadrature_pwm_channel_tb.sv]
`timescale 1ns/1ps
`include "tqp_map.svh"
`default_nettype none
module timer_quadrature_pwm_channel_tb;
    logic pclk, presetn, psel, penable, pwrite, step, up, sel_cd, m_a, m_c, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, out_a, out_b, count_pulse, ph_a, ph_b;
    int errors = 0;
    int compares = 0;
    int pulses = 0;

    tqp_encoder u_enc (.pclk(pclk), .presetn(presetn), .step(step), .up(up),
        .phase_a(ph_a), .phase_b(ph_b));

    // Unused pin pair idles low; encoder returns to 00 before any switch
    tqp_channel u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .ext_phase_pin_a(sel_cd ? 1'b0 : ph_a), .ext_phase_pin_b(sel_cd ? 1'b0 : ph_b),
        .ext_phase_pin_c(sel_cd ? ph_a : 1'b0), .ext_phase_pin_d(sel_cd ? ph_b : 1'b0),
        .chan0_match_a(m_a), .chan0_match_c(m_c), .out_a(out_a), .out_b(out_b),
        .count_pulse(count_pulse));

    // ----------------------------------------
    // Clock and step pulse tally
    // ----------------------------------------
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    always @(posedge pclk) if (count_pulse === 1'b1) pulses++;

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic report_and_stop;
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Setup then access; waits on pready, never on a fixed count
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            errors++;
            report_and_stop();
        end
    endtask

    // Pins hold well over three clocks so every edge is seen
    task automatic enc_step(input logic dir_up);
        @(posedge pclk);
        step <= 1'b1;
        up <= dir_up;
        @(posedge pclk);
        step <= 1'b0;
        repeat (6) @(posedge pclk);
    endtask

    function automatic logic [31:0] ctl(input logic [2:0] id, input logic [2:0] md);
        return {20'h0, id, md, 6'h00};
    endfunction

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        apb(1'b0, `TQP_CTL_OFF, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, `TQP_STS_OFF, 32'h0);
        check(rd, 32'h80);
        apb(1'b0, `TQP_GRA_OFF, 32'h0);
        check(rd, 32'hFFFF);
        apb(1'b1, 8'h1C, 32'h5);
        check({31'h0, err}, 32'h1);
    endtask

    // Full encoder cycle each way; net steps differ per sub-mode
    task automatic t_submodes;
        int ups[4] = '{4, 1, 1, 2};
        int p0;
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, `TQP_CTL_OFF, ctl(3'h1, 3'(4 + m)));
            apb(1'b1, `TQP_CNT_OFF, 32'h0);
            p0 = pulses;
            repeat (4) enc_step(1'b1);
            apb(1'b0, `TQP_CNT_OFF, 32'h0);
            check(rd, 32'(ups[m]));
            repeat (4) enc_step(1'b0);
            apb(1'b0, `TQP_CNT_OFF, 32'h0);
            check(rd, 32'h0);
            check(32'(pulses - p0), 32'(2 * ups[m]));
        end
    endtask

    task automatic t_wrap;
        apb(1'b1, `TQP_CTL_OFF, ctl(3'h1, 3'h4));
        apb(1'b1, `TQP_CNT_OFF, 32'h0);
        apb(1'b1, `TQP_STS_OFF, 32'h33);
        enc_step(1'b0);
        apb(1'b0, `TQP_CNT_OFF, 32'h0);
        check(rd, 32'hFFFF);
        apb(1'b0, `TQP_STS_OFF, 32'h0);
        check(rd & 32'hB0, 32'h20);
        apb(1'b1, `TQP_STS_OFF, 32'h33);
        enc_step(1'b1);
        apb(1'b0, `TQP_CNT_OFF, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, `TQP_STS_OFF, 32'h0);
        check(rd & 32'hB0, 32'h90);
    endtask

    task automatic t_pins;
        apb(1'b1, `TQP_CTL_OFF, ctl(3'h2, 3'h4));
        apb(1'b1, `TQP_CNT_OFF, 32'h0);
        repeat (4) enc_step(1'b1);
        apb(1'b0, `TQP_CNT_OFF, 32'h0);
        check(rd, 32'h0);
        sel_cd <= 1'b1;
        repeat (4) enc_step(1'b1);
        apb(1'b0, `TQP_CNT_OFF, 32'h0);
        check(rd, 32'h4);
        sel_cd <= 1'b0;
        apb(1'b1, `TQP_CTL_OFF, ctl(3'h3, 3'h4));
        apb(1'b1, `TQP_CNT_OFF, 32'h0);
        apb(1'b0, `TQP_CNT_OFF, 32'h0);
        check({31'h0, rd[15:0] != 16'h0}, 32'h1);
    endtask

    task automatic t_capture;
        apb(1'b1, `TQP_CTL_OFF, ctl(3'h1, 3'h4));
        apb(1'b1, `TQP_IOC_OFF, 32'h88);
        apb(1'b1, `TQP_CNT_OFF, 32'h1234);
        apb(1'b1, `TQP_STS_OFF, 32'h33);
        m_a <= 1'b1;
        @(posedge pclk);
        m_a <= 1'b0;
        m_c <= 1'b1;
        @(posedge pclk);
        m_c <= 1'b0;
        apb(1'b0, `TQP_GRA_OFF, 32'h0);
        check(rd, 32'h1234);
        apb(1'b0, `TQP_GRB_OFF, 32'h0);
        check(rd, 32'h1234);
        apb(1'b0, `TQP_STS_OFF, 32'h0);
        check(rd & 32'h3, 32'h3);
    endtask

    // Clocks out of 100 that one pin is high, once the waveform has settled
    task automatic high_count(input logic use_b, output int hi);
        repeat (30) @(posedge pclk);
        hi = 0;
        repeat (100) begin
            @(posedge pclk);
            if ((use_b ? out_b : out_a) === 1'b1) hi++;
        end
    endtask

    // Period 10 clocks, high from match B (4) to match A (9); counter restarts
    // from 0, else the old capture value would run for a full wrap first.
    // Equal registers hold the initial level: 100% or 0% duty.
    task automatic t_pwm;
        int hi;
        apb(1'b1, `TQP_GRA_OFF, 32'h9);
        apb(1'b1, `TQP_GRB_OFF, 32'h4);
        apb(1'b1, `TQP_IOC_OFF, 32'h10);
        apb(1'b1, `TQP_CNT_OFF, 32'h0);
        apb(1'b1, `TQP_CTL_OFF, {23'h0, 3'h2, 4'h0, 2'h1});
        high_count(1'b0, hi);
        check(32'(hi), 32'd50);
        apb(1'b1, `TQP_GRB_OFF, 32'h9);
        apb(1'b1, `TQP_IOC_OFF, 32'h14);
        high_count(1'b0, hi);
        check(32'(hi), 32'd100);
        apb(1'b1, `TQP_IOC_OFF, 32'h10);
        high_count(1'b0, hi);
        check(32'(hi), 32'd0);
        apb(1'b1, `TQP_GRB_OFF, 32'h4);
        apb(1'b1, `TQP_CTL_OFF, {23'h0, 3'h3, 4'h0, 2'h1});
        high_count(1'b1, hi);
        check(32'(hi), 32'd50);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        step = 1'b0;
        up = 1'b1;
        sel_cd = 1'b0;
        m_a = 1'b0;
        m_c = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_submodes();
        t_wrap();
        t_pins();
        t_capture();
        t_pwm();
        report_and_stop();
    end
endmodule // timer_quadrature_pwm_channel_tb
`default_nettype wire
